// ==== rtl/sgcmd_pkg.sv ====
// Shared constants, command codes, states and carriers of the graphics DRAM command block
package sgcmd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W     = 11;
  localparam int COL_W      = 8;
  localparam int LOW_COL_W  = 3;
  localparam int DQ_W       = 32;
  localparam int BYTES      = 4;
  localparam int BLOCK_COLS = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Operating mode setting layout and value after reset
  localparam int          MODE_W      = 11;
  localparam logic [10:0] MODE_RESET  = 11'h022;
  localparam int          BL_LSB      = 0;
  localparam int          ORDER_BIT   = 3;
  localparam int          LAT_LSB     = 4;
  localparam int          TM_LSB      = 7;
  localparam int          WSINGLE_BIT = 9;
  localparam int          RSV_BIT     = 10;
  localparam logic [2:0]  LAT_2       = 3'h2;
  localparam logic [2:0]  LAT_3       = 3'h3;
  localparam logic [2:0]  BL_1        = 3'h0;
  localparam logic [2:0]  BL_2        = 3'h1;
  localparam logic [2:0]  BL_4        = 3'h2;
  localparam logic [2:0]  BL_8        = 3'h3;
  localparam logic [2:0]  BL_PAGE     = 3'h7;

  // Burst lengths minus one; full page is 256 columns
  localparam logic [7:0] LEN_1    = 8'h00;
  localparam logic [7:0] LEN_2    = 8'h01;
  localparam logic [7:0] LEN_4    = 8'h03;
  localparam logic [7:0] LEN_8    = 8'h07;
  localparam logic [7:0] LEN_PAGE = 8'hff;

  ////////////////////////////////////////////////////////////////////////////////
  // Address bit roles during commands
  localparam int MASK_SEL_BIT   = 5;
  localparam int COLOUR_SEL_BIT = 6;
  localparam int AUTO_PRE_BIT   = 9;
  localparam int ALL_BANKS_BIT  = 9;
  localparam int BANK_BIT       = 10;

  // Read mask latency in clocks; the output stage adds one register of it
  localparam int DQM_RD_LAT = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Command codes of {row strobe, column strobe, write enable}, all active low
  localparam logic [2:0] CMD_PROGRAM = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECH   = 3'h2;
  localparam logic [2:0] CMD_ACT     = 3'h3;
  localparam logic [2:0] CMD_WRITE   = 3'h4;
  localparam logic [2:0] CMD_READ    = 3'h5;
  localparam logic [2:0] CMD_STOP    = 3'h6;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_RD      = 5'h02,
    ST_WR      = 5'h04,
    ST_PWRDN   = 5'h08,
    ST_SELFREF = 5'h10
  } sgcmd_state_e;

  typedef struct packed {
    logic chip_sel_b;
    logic row_strobe_b;
    logic col_strobe_b;
    logic write_en_b;
    logic special_function_select;
  } sgcmd_cmd_s;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [1:0]        bank_open;
    logic              power_down;
    logic              self_refresh;
  } sgcmd_status_s;

endpackage

// ==== rtl/sgcmd_mem.sv ====
// Cell array: bit-writable words of eight columns with registered read data
`timescale 1ns/100ps
module sgcmd_mem #(
  parameter int AW = 16,
  parameter int DW = 256
) (
  input  wire logic          clk_i,
  input  wire logic          re_i,
  input  wire logic [DW-1:0] we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wd_i,
  output logic      [DW-1:0] rd_o
);

  logic [DW-1:0] cells [2**AW];

  ////////////////////////////////////////////////////////////////////////////////
  // No reset: array contents are undefined at power-up, like the real cells
  always_ff @(posedge clk_i) begin
    if (re_i) begin
      rd_o <= cells[addr_i];
    end
    cells[addr_i] <= (cells[addr_i] & ~we_i) | (wd_i & we_i);
  end

endmodule

// ==== rtl/sgcmd_top.sv ====
// Command, mode and burst logic of a two-bank graphics DRAM with status crossing
`timescale 1ns/100ps
module sgcmd_top #(
  parameter int ROW_W = 10
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      link_clk_i,
  input  wire logic                      cke_i,
  input  wire sgcmd_pkg::sgcmd_cmd_s     cmd_i,
  input  wire logic [10:0]               addr_i,
  input  wire logic [3:0]                dqm_i,
  input  wire logic [31:0]               dq_i,
  output logic      [31:0]               dq_o,
  output logic      [3:0]                dq_oe_o,
  output sgcmd_pkg::sgcmd_status_s       status_o
);

  localparam int MEM_AW = 1 + ROW_W + sgcmd_pkg::COL_W - sgcmd_pkg::LOW_COL_W;
  localparam int MEM_DW = sgcmd_pkg::DQ_W * sgcmd_pkg::BLOCK_COLS;

  ////////////////////////////////////////////////////////////////////////////////
  // State carriers of the two clock domains
  typedef struct packed {
    sgcmd_pkg::sgcmd_state_e  state;
    logic                     cke_q;
    logic [10:0]              mode;
    logic [31:0]              wmask;
    logic [31:0]              colour;
    logic [1:0]               open;
    logic [1:0]               wpb;
    logic [1:0][ROW_W-1:0]    row;
    logic                     bank;
    logic                     auto_pre;
    logic [7:0]               start_col;
    logic [7:0]               beat;
    logic [7:0]               len_m1;
    logic                     rd0_v;
    logic [2:0]               rd0_col;
    logic                     rd1_v;
    logic [31:0]              rd1_word;
    logic [3:0]               dqm_q;
    logic [31:0]              dq;
    logic [3:0]               dq_oe;
    sgcmd_pkg::sgcmd_status_s snap;
    logic                     req;
    logic                     ack_s1;
    logic                     ack_s2;
  } sgcmd_link_s;

  typedef struct packed {
    logic                     req_s1;
    logic                     req_s2;
    logic                     ack;
    sgcmd_pkg::sgcmd_status_s status;
  } sgcmd_core_s;

  localparam sgcmd_link_s L_RESET = '{state: sgcmd_pkg::ST_IDLE,
                                      mode:  sgcmd_pkg::MODE_RESET,
                                      default: '0};
  localparam sgcmd_core_s C_RESET = '0;

  sgcmd_link_s l_q, l_d;
  sgcmd_core_s c_q, c_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Reserved length codes behave as single-word bursts
  function automatic logic [7:0] sgcmd_len_m1(input logic [2:0] code);
    logic [7:0] len;
    len = sgcmd_pkg::LEN_1;
    case (code)
      sgcmd_pkg::BL_2:    len = sgcmd_pkg::LEN_2;
      sgcmd_pkg::BL_4:    len = sgcmd_pkg::LEN_4;
      sgcmd_pkg::BL_8:    len = sgcmd_pkg::LEN_8;
      sgcmd_pkg::BL_PAGE: len = sgcmd_pkg::LEN_PAGE;
      default:            len = sgcmd_pkg::LEN_1;
    endcase
    return len;
  endfunction

  // Column of a burst beat; bits above the burst size stay at the start column
  function automatic logic [7:0] sgcmd_beat_col(input logic [7:0] start,
                                                input logic [7:0] beat,
                                                input logic [7:0] m,
                                                input logic       burst_order);
    logic [7:0] off;
    off = burst_order ? (start ^ beat) : 8'(start + beat);
    return (start & ~m) | (off & m);
  endfunction

  function automatic logic [31:0] sgcmd_bytes(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode; commands count only when the gate was high on the last edge
  logic       run;
  logic       sel;
  logic [2:0] code;
  logic       sfs;
  logic       is_mrs;
  logic       is_special_mode_program_cmd;
  logic       is_ref;
  logic       is_act;
  logic       is_rd;
  logic       is_wr;
  logic       is_pre;
  logic       is_stop;
  logic       lat3;

  assign run     = l_q.cke_q;
  assign sel     = run & ~cmd_i.chip_sel_b;
  assign code    = {cmd_i.row_strobe_b, cmd_i.col_strobe_b, cmd_i.write_en_b};
  assign sfs     = cmd_i.special_function_select;
  assign is_mrs  = sel & (code == sgcmd_pkg::CMD_PROGRAM) & ~sfs;
  assign is_special_mode_program_cmd = sel & (code == sgcmd_pkg::CMD_PROGRAM) & sfs;
  assign is_ref  = sel & (code == sgcmd_pkg::CMD_REFRESH);
  assign is_act  = sel & (code == sgcmd_pkg::CMD_ACT);
  assign is_rd   = sel & (code == sgcmd_pkg::CMD_READ);
  assign is_wr   = sel & (code == sgcmd_pkg::CMD_WRITE);
  assign is_pre  = sel & (code == sgcmd_pkg::CMD_PRECH);
  assign is_stop = sel & (code == sgcmd_pkg::CMD_STOP);
  assign lat3    = l_q.mode[sgcmd_pkg::LAT_LSB +: 3] == sgcmd_pkg::LAT_3;

  ////////////////////////////////////////////////////////////////////////////////
  // Array access signals
  logic              acc_v;
  logic              acc_wr;
  logic              acc_blk;
  logic              acc_bank;
  logic [7:0]        acc_col;
  logic [31:0]       lane;
  logic [MEM_DW-1:0] blk_we;
  logic [MEM_DW-1:0] mem_we;
  logic [MEM_DW-1:0] mem_wd;
  logic [MEM_DW-1:0] mem_rd;
  logic [MEM_AW-1:0] mem_addr;
  logic [31:0]       rd_word;

  // Byte masks block write data in the same cycle; write mask applies per bank
  assign lane = ~sgcmd_bytes(dqm_i)
              & (l_q.wpb[acc_bank] ? l_q.wmask : 32'hffffffff);

  // Each byte's bit n enables column n of the eight-column block
  for (genvar c = 0; c < sgcmd_pkg::BLOCK_COLS; c++) begin : g_blk
    assign blk_we[c*32 +: 32] = lane & sgcmd_bytes({dq_i[24+c], dq_i[16+c],
                                                    dq_i[8+c], dq_i[c]});
  end

  assign mem_addr = {acc_bank, l_q.row[acc_bank], acc_col[7:3]};
  assign rd_word  = mem_rd[{l_q.rd0_col, 5'h00} +: 32];

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain next state
  always_comb begin
    l_d      = l_q;
    acc_v    = 1'b0;
    acc_wr   = 1'b0;
    acc_blk  = 1'b0;
    acc_bank = l_q.bank;
    acc_col  = sgcmd_beat_col(l_q.start_col, l_q.beat, l_q.len_m1,
                              l_q.mode[sgcmd_pkg::ORDER_BIT]);
    l_d.cke_q = cke_i;
    l_d.dqm_q = dqm_i;
    if (run) begin
      // Running burst issues its next beat unless a command below overrides it
      if (l_q.state == sgcmd_pkg::ST_RD || l_q.state == sgcmd_pkg::ST_WR) begin
        acc_v    = 1'b1;
        acc_wr   = l_q.state == sgcmd_pkg::ST_WR;
        l_d.beat = 8'(l_q.beat + 8'h01);
        if (l_q.beat == l_q.len_m1) begin
          l_d.state = sgcmd_pkg::ST_IDLE;
          if (l_q.auto_pre) begin
            l_d.open[l_q.bank] = 1'b0;
          end
        end
      end
      if (is_rd || is_wr) begin
        acc_v         = 1'b1;
        acc_wr        = is_wr;
        acc_blk       = is_wr & sfs;
        acc_bank      = addr_i[sgcmd_pkg::BANK_BIT];
        acc_col       = addr_i[7:0];
        l_d.bank      = addr_i[sgcmd_pkg::BANK_BIT];
        l_d.auto_pre  = addr_i[sgcmd_pkg::AUTO_PRE_BIT];
        l_d.start_col = addr_i[7:0];
        l_d.beat      = 8'h01;
        l_d.len_m1    = sgcmd_len_m1(l_q.mode[sgcmd_pkg::BL_LSB +: 3]);
        if (is_wr && (sfs || l_q.mode[sgcmd_pkg::WSINGLE_BIT])) begin
          l_d.len_m1 = sgcmd_pkg::LEN_1;
        end
        if (l_d.len_m1 == sgcmd_pkg::LEN_1) begin
          l_d.state = sgcmd_pkg::ST_IDLE;
          if (addr_i[sgcmd_pkg::AUTO_PRE_BIT]) begin
            l_d.open[addr_i[sgcmd_pkg::BANK_BIT]] = 1'b0;
          end
        end else begin
          l_d.state = is_rd ? sgcmd_pkg::ST_RD : sgcmd_pkg::ST_WR;
        end
      end else if (is_stop) begin
        acc_v     = 1'b0;
        l_d.state = sgcmd_pkg::ST_IDLE;
        l_d.beat  = l_q.beat;
      end else if (is_pre) begin
        // Precharge of the bursting bank also ends the burst
        if (addr_i[sgcmd_pkg::ALL_BANKS_BIT]) begin
          l_d.open = 2'b00;
        end else begin
          l_d.open[addr_i[sgcmd_pkg::BANK_BIT]] = 1'b0;
        end
        if (addr_i[sgcmd_pkg::ALL_BANKS_BIT] || addr_i[sgcmd_pkg::BANK_BIT] == l_q.bank) begin
          acc_v     = 1'b0;
          l_d.state = sgcmd_pkg::ST_IDLE;
          l_d.open  = l_d.open;
        end
      end else if (is_act) begin
        l_d.open[addr_i[sgcmd_pkg::BANK_BIT]] = 1'b1;
        l_d.row[addr_i[sgcmd_pkg::BANK_BIT]]  = addr_i[ROW_W-1:0];
        l_d.wpb[addr_i[sgcmd_pkg::BANK_BIT]]  = sfs;
      end else if (is_mrs) begin
        l_d.mode = addr_i;
      end else if (is_special_mode_program_cmd) begin
        // Setting both selects loads both from the same data word
        if (addr_i[sgcmd_pkg::MASK_SEL_BIT]) begin
          l_d.wmask = dq_i;
        end
        if (addr_i[sgcmd_pkg::COLOUR_SEL_BIT]) begin
          l_d.colour = dq_i;
        end
      end else if (is_ref && !cke_i) begin
        l_d.state = sgcmd_pkg::ST_SELFREF;
      end
      // Gate falling with both banks idle enters power-down
      if (!cke_i && l_d.state == sgcmd_pkg::ST_IDLE && l_d.open == 2'b00) begin
        l_d.state = sgcmd_pkg::ST_PWRDN;
      end
      // Read pipeline: array register, optional extra stage, output register
      l_d.rd0_v    = acc_v & ~acc_wr;
      l_d.rd0_col  = acc_col[2:0];
      l_d.rd1_v    = l_q.rd0_v;
      l_d.rd1_word = rd_word;
      l_d.dq       = lat3 ? l_q.rd1_word : rd_word;
      l_d.dq_oe    = (lat3 ? l_q.rd1_v : l_q.rd0_v) ? ~l_q.dqm_q : 4'h0;
    end else if (cke_i && (l_q.state == sgcmd_pkg::ST_PWRDN ||
                           l_q.state == sgcmd_pkg::ST_SELFREF)) begin
      l_d.state = sgcmd_pkg::ST_IDLE;
    end
    // Status snapshot handed over only when the previous one was taken
    l_d.ack_s1 = c_q.ack;
    l_d.ack_s2 = l_q.ack_s1;
    if (l_q.req == l_q.ack_s2 &&
        l_q.snap != {l_q.mode, l_q.open, l_q.state == sgcmd_pkg::ST_PWRDN,
                     l_q.state == sgcmd_pkg::ST_SELFREF}) begin
      l_d.snap = {l_q.mode, l_q.open, l_q.state == sgcmd_pkg::ST_PWRDN,
                  l_q.state == sgcmd_pkg::ST_SELFREF};
      l_d.req  = ~l_q.req;
    end
  end

  // Write enables: whole block, or one column slice of the normal write
  always_comb begin
    mem_we = '0;
    mem_wd = acc_blk ? {sgcmd_pkg::BLOCK_COLS{l_q.colour}}
                     : {sgcmd_pkg::BLOCK_COLS{dq_i}};
    if (acc_v && acc_wr) begin
      mem_we = acc_blk ? blk_we : (MEM_DW'(lane) << {acc_col[2:0], 5'h00});
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain register; frozen cycles keep l_q apart from the gate, mask, wake-up and status handshake fields
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      l_q <= L_RESET;
    end else begin
      l_q <= l_d;
    end
  end

  // Array read is disabled while frozen so its output register holds too
  sgcmd_mem #(
    .AW (MEM_AW),
    .DW (MEM_DW)
  ) u_mem (
    .clk_i  (link_clk_i),
    .re_i   (acc_v & ~acc_wr),
    .we_i   (mem_we),
    .addr_i (mem_addr),
    .wd_i   (mem_wd),
    .rd_o   (mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain: the snapshot is stable while the request toggle is in flight
  always_comb begin
    c_d        = c_q;
    c_d.req_s1 = l_q.req;
    c_d.req_s2 = c_q.req_s1;
    if (c_q.req_s2 != c_q.ack) begin
      c_d.status = l_q.snap;
      c_d.ack    = c_q.req_s2;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      c_q <= C_RESET;
    end else begin
      c_q <= c_d;
    end
  end

  assign dq_o     = l_q.dq;
  assign dq_oe_o  = l_q.dq_oe;
  assign status_o = c_q.status;

endmodule

// ==== tb/sgcmd_ctrl.sv ====
// Behavioural memory controller that drives the command bus on the link clock
`timescale 1ns/100ps
module sgcmd_ctrl #(
  parameter int PWR_WAIT = 20
) (
  input  wire logic             link_clk_i,
  output logic                  cke_o,
  output sgcmd_pkg::sgcmd_cmd_s cmd_o,
  output logic [10:0]           addr_o,
  output logic [3:0]            dqm_o,
  output logic [31:0]           dq_o
);
  localparam logic [4:0] NOP = 5'h0e;

  // Power-up level on the pins: gate and masks high, no-operation
  initial begin
    cke_o = 1'b1;
    cmd_o = sgcmd_pkg::sgcmd_cmd_s'(NOP);
    addr_o = 11'h000;
    dqm_o = 4'hf;
    dq_o = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One command a link cycle, set at the falling edge and held over one rise
  task automatic op(input logic [4:0] c, input logic [10:0] a, input logic [3:0] m,
                    input logic [31:0] d);
    @(negedge link_clk_i);
    cmd_o = sgcmd_pkg::sgcmd_cmd_s'(c);
    addr_o = a;
    dqm_o = m;
    dq_o = d;
  endtask

  // Released data lines flip every cycle so a stale copy never passes for data
  task automatic idle(input int n);
    repeat (n) op(NOP, addr_o, 4'h0, ~dq_o);
  endtask

  // Gate changes alone; callers idle a cycle before the next command
  task automatic gate(input logic v);
    @(negedge link_clk_i);
    cke_o = v;
  endtask

  // Refresh with the gate falling in the same cycle enters self-refresh
  task automatic self_ref();
    op(5'h02, 11'h000, 4'h0, 32'h0);
    cke_o = 1'b0;
  endtask

  // Pause, close both banks, two refreshes, then program the mode
  task automatic power_up();
    repeat (PWR_WAIT) op(NOP, 11'h000, 4'hf, 32'h0);
    op(5'h04, 11'h200, 4'h0, 32'h0);
    idle(3);
    repeat (2) begin
      op(5'h02, 11'h000, 4'h0, 32'h0);
      idle(8);
    end
    op(5'h00, {1'b0, 10'h032}, 4'h0, 32'h0);
    idle(12);
  endtask
endmodule

// ==== tb/sgcmd_chk.sv ====
// Port checker of the graphics DRAM command block, bound to its top module
`timescale 1ns/100ps
module sgcmd_chk (
  input wire logic                     core_clk_i,
  input wire logic                     rst_b_i,
  input wire logic                     link_clk_i,
  input wire logic                     cke_i,
  input wire sgcmd_pkg::sgcmd_cmd_s    cmd_i,
  input wire logic [10:0]              addr_i,
  input wire logic [3:0]               dqm_i,
  input wire logic [31:0]              dq_i,
  input wire logic [31:0]              dq_o,
  input wire logic [3:0]               dq_oe_o,
  input wire sgcmd_pkg::sgcmd_status_s status_o
);
  logic       cke_q, bank_q, live, prog, rd, act, pre_all;
  logic [3:0] since_q;
  logic [10:0] mode_q;

  // A command counts only if the gate was high at the previous rise
  assign live = cke_q && !cmd_i.chip_sel_b;
  assign prog = live && cmd_i[3:1] == sgcmd_pkg::CMD_PROGRAM && !cmd_i[0];
  assign rd = live && cmd_i[3:1] == sgcmd_pkg::CMD_READ;
  assign act = live && cmd_i[3:1] == sgcmd_pkg::CMD_ACT;
  assign pre_all = live && cmd_i[3:1] == sgcmd_pkg::CMD_PRECH && addr_i[9];

  // Reset counts as a fresh program so the post-reset status update is allowed
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cke_q <= 1'b0;
      bank_q <= 1'b0;
      since_q <= 4'h0;
      mode_q <= sgcmd_pkg::MODE_RESET;
    end else begin
      cke_q <= cke_i;
      bank_q <= act ? addr_i[10] : bank_q;
      mode_q <= prog ? addr_i : mode_q;
      since_q <= prog ? 4'h0 : (since_q == 4'hf ? since_q : since_q + 4'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_oe_cause;
    @(posedge link_clk_i) disable iff (!rst_b_i) $rose(|dq_oe_o) |-> $past(rd, 2) || $past(rd, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive began without a read");
  property p_rd_mask;
    @(posedge link_clk_i) disable iff (!rst_b_i)
      (cke_i && dqm_i != 4'h0) |-> ##2 (dq_oe_o & $past(dqm_i, 2)) == 4'h0;
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("masked byte still driven");
  property p_freeze;
    @(posedge link_clk_i) disable iff (!rst_b_i) !cke_i |-> ##2 ($stable(dq_o) && $stable(dq_oe_o));
  endproperty
  a_freeze: assert property (p_freeze) else $error("output moved while gated");
  property p_pd_idle;
    @(posedge core_clk_i) disable iff (!rst_b_i) status_o.power_down |-> status_o.bank_open == 2'h0;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("power down with open bank");
  property p_mode_cap;
    @(posedge link_clk_i) disable iff (!rst_b_i) prog |=> ##[0:8] status_o.mode == mode_q;
  endproperty
  a_mode_cap: assert property (p_mode_cap) else $error("mode not taken from address");
  property p_mode_cause;
    @(posedge link_clk_i) disable iff (!rst_b_i) $changed(status_o.mode) |-> since_q < 4'hc;
  endproperty
  a_mode_cause: assert property (p_mode_cause) else $error("mode changed unprogrammed");
  property p_act;
    @(posedge link_clk_i) disable iff (!rst_b_i) act |=> ##[0:8] status_o.bank_open[bank_q];
  endproperty
  a_act: assert property (p_act) else $error("activated bank not open");
  property p_pre_all;
    @(posedge link_clk_i) disable iff (!rst_b_i) pre_all |=> ##[0:8] status_o.bank_open == 2'h0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("banks not closed");

  c_read: cover property (@(posedge link_clk_i) disable iff (!rst_b_i) $rose(|dq_oe_o));
  c_prog: cover property (@(posedge link_clk_i) disable iff (!rst_b_i) prog);
  c_pd: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) $rose(status_o.power_down));
endmodule

bind sgcmd_top sgcmd_chk chk_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .link_clk_i(link_clk_i), .cke_i(cke_i), .cmd_i(cmd_i), .addr_i(addr_i), .dqm_i(dqm_i),
  .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .status_o(status_o));

// ==== tb/tb_top.sv ====
// Self-checking bench: controller model drives the command block, results judged here
`timescale 1ns/100ps
module tb_top;
  logic                     core_clk, link_clk, rst_b, cke;
  logic [10:0]              addr;
  logic [3:0]               dqm, oe;
  logic [31:0]              dqi, dqo;
  logic [31:0]              w [8];
  sgcmd_pkg::sgcmd_cmd_s    cmd;
  sgcmd_pkg::sgcmd_status_s st;
  int                       fails = 0;
  int                       num_checks = 0;
  int                       cyc = 0;

  // Link clock is unrelated in phase to the core clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #40 link_clk = ~link_clk;
  end

  sgcmd_top #(.ROW_W(2)) dut_u (.core_clk_i(core_clk), .rst_b_i(rst_b), .link_clk_i(link_clk),
    .cke_i(cke), .cmd_i(cmd), .addr_i(addr), .dqm_i(dqm), .dq_i(dqi), .dq_o(dqo),
    .dq_oe_o(oe), .status_o(st));
  sgcmd_ctrl c_u (.link_clk_i(link_clk), .cke_o(cke), .cmd_o(cmd), .addr_o(addr),
    .dqm_o(dqm), .dq_o(dqi));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_dq(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_st(input string what, input logic [10:0] e, input logic [10:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [31:0] bytes(input logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  // Reads one burst into the compare against w[]; mask m is aimed at the first word at latency 3 only
  task automatic read_cmp(input logic [10:0] a, input int lat, input int n, input logic [3:0] m);
    logic [3:0] en;
    c_u.op(5'h0a, a, 4'h0, ~dqi);
    c_u.op(5'h0e, a, m, ~dqi);
    c_u.idle(lat - 1);
    for (int i = 0; i < n; i++) begin
      en = (i == 0) ? ~m : 4'hf;
      chk_dq("read word", w[i] & bytes(en), dqo & bytes(en));
      chk_dq("read drive", {28'h0, en}, {28'h0, oe});
      c_u.idle(1);
    end
    chk_dq("drive off", 32'h0, {28'h0, oe});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // A deselected program must not touch the mode; a selected one sets it
  task automatic t_mode();
    c_u.op(5'h10, 11'h03a, 4'h0, ~dqi);
    c_u.idle(12);
    chk_st("mode kept", 11'h032, st.mode);
    c_u.op(5'h00, 11'h03a, 4'h0, ~dqi);
    c_u.idle(12);
    chk_st("mode set", 11'h03a, st.mode);
    $display("t_mode done");
  endtask

  // Interleaved four-beat write from column 2, read back from column 1 at latency 3
  task automatic t_wr_rd();
    c_u.op(5'h06, 11'h401, 4'h0, ~dqi);
    c_u.idle(10);
    chk_st("bank b open", 11'h002, {9'h0, st.bank_open});
    for (int j = 0; j < 4; j++) c_u.op(j == 0 ? 5'h08 : 5'h0e, 11'h402, 4'h0, 32'hc0de_0000 + j);
    c_u.idle(1);
    for (int i = 0; i < 4; i++) w[i] = 32'hc0de_0003 - 32'(i);
    read_cmp(11'h401, 3, 4, 4'h2);
    $display("t_wr_rd done");
  endtask

  // Fill colour, block write over eight columns, sequential wrapped read at latency 2
  task automatic t_block();
    logic [2:0] col;
    c_u.op(5'h04, 11'h200, 4'h0, ~dqi);
    c_u.idle(3);
    c_u.op(5'h00, 11'h023, 4'h0, ~dqi);
    c_u.op(5'h06, 11'h000, 4'h0, ~dqi);
    c_u.idle(2);
    for (int j = 0; j < 8; j++) c_u.op(j == 0 ? 5'h08 : 5'h0e, 11'h000, 4'h0, 32'h0);
    c_u.idle(2);
    c_u.op(5'h01, 11'h040, 4'h0, 32'ha5c3_5a3c);
    c_u.idle(1);
    c_u.op(5'h09, 11'h000, 4'h0, 32'h0180_00ff);
    c_u.idle(2);
    for (int i = 0; i < 8; i++) begin
      col = 3'(5 + i);
      w[i] = 32'ha5c3_5a3c & bytes({col == 3'h0, col == 3'h7, 1'b0, 1'b1});
    end
    read_cmp(11'h005, 2, 8, 4'h0);
    $display("t_block done");
  endtask

  // Close both banks, gate the clock into power-down, try a program, wake up
  task automatic t_pwrdn();
    c_u.op(5'h04, 11'h600, 4'h0, ~dqi);
    c_u.idle(10);
    chk_st("banks closed", 11'h000, {9'h0, st.bank_open});
    c_u.gate(1'b0);
    c_u.idle(10);
    chk_st("power down", 11'h001, {10'h0, st.power_down});
    c_u.op(5'h00, 11'h021, 4'h0, ~dqi);
    c_u.idle(10);
    chk_st("mode in pd", 11'h023, st.mode);
    c_u.gate(1'b1);
    c_u.idle(10);
    chk_st("awake", 11'h000, {10'h0, st.power_down});
    $display("t_pwrdn done");
  endtask

  // Mask load, per-bit single write with auto precharge, burst stop, self-refresh
  task automatic t_gfx();
    logic [2:0] col;
    c_u.op(5'h00, 11'h223, 4'h0, ~dqi);
    c_u.op(5'h01, 11'h020, 4'h0, 32'hffff_0000);
    c_u.op(5'h07, 11'h000, 4'h0, ~dqi);
    c_u.idle(3);
    c_u.op(5'h08, 11'h201, 4'h8, 32'h1234_5678);
    // A second beat here would land in column 2 if writes were not single
    c_u.op(5'h0e, 11'h000, 4'h0, 32'h9abc_def0);
    c_u.idle(10);
    chk_st("auto close", 11'h000, {9'h0, st.bank_open});
    c_u.op(5'h06, 11'h000, 4'h0, ~dqi);
    c_u.idle(2);
    c_u.op(5'h0a, 11'h000, 4'h0, ~dqi);
    c_u.op(5'h0c, 11'h000, 4'h0, ~dqi);
    c_u.idle(1);
    chk_dq("stop word", 32'ha500_003c, dqo);
    c_u.idle(1);
    chk_dq("stop drive", 32'h0, {28'h0, oe});
    for (int i = 0; i < 8; i++) begin
      col = 3'(1 + i);
      w[i] = 32'ha5c3_5a3c & bytes({col == 3'h0, col == 3'h7, 1'b0, 1'b1});
    end
    w[0] = 32'h0034_003c;
    read_cmp(11'h001, 2, 8, 4'h0);
    c_u.op(5'h04, 11'h200, 4'h0, ~dqi);
    c_u.idle(3);
    c_u.self_ref();
    c_u.idle(10);
    chk_st("self refresh", 11'h001, {9'h0, st.power_down, st.self_refresh});
    c_u.gate(1'b1);
    c_u.idle(10);
    chk_st("refresh exit", 11'h000, {9'h0, st.power_down, st.self_refresh});
    $display("t_gfx done");
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Whole run needs about 2500 core cycles; the ceiling leaves wide margin
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    rst_b = 1'b0;
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    c_u.power_up();
    t_mode();
    t_wr_rd();
    t_block();
    t_pwrdn();
    t_gfx();
    tally_and_finish();
  end
endmodule
